// *** logic/odq_pkg.sv ***
// package: constants for the output disable request qualifier
`default_nettype none
package odq_pkg;
  localparam int          ODQ_ADDR_W      = 4;
  localparam logic [3:0]  ODQ_MODE_ADDR   = 4'h0;
  localparam logic [3:0]  ODQ_STAT_ADDR   = 4'h4;
  localparam logic [3:0]  ODQ_MASK_ADDR   = 4'h8;
  localparam logic [3:0]  ODQ_LVL_ADDR    = 4'hc;
  localparam int          ODQ_M1_LO       = 2;
  localparam int          ODQ_M2_LO       = 4;
  localparam logic [1:0]  ODQ_MODE_RST    = 2'h0;
  localparam logic [1:0]  ODQ_STAT_RST    = 2'h0;
  localparam logic [1:0]  ODQ_MASK_RST    = 2'h0;
  localparam int          ODQ_SAMPLES     = 16;
  localparam int          ODQ_DIV_A       = 8;
  localparam int          ODQ_DIV_B       = 16;
  localparam int          ODQ_DIV_C       = 128;
  localparam int          ODQ_PRE_W       = 7;
  typedef enum logic [1:0] {
    ODQ_EDGE   = 2'b00,
    ODQ_DIV8   = 2'b01,
    ODQ_DIV16  = 2'b10,
    ODQ_DIV128 = 2'b11
  } odq_mode_t;
endpackage
`default_nettype wire

// *** logic/odq_if.sv ***
// interface: qualifier channel between top and one input qualifier
`default_nettype none
interface odq_chan_if;
  logic [1:0] mode;
  logic       tick8;
  logic       tick16;
  logic       tick128;
  logic       req_n;
  logic       accept;
  modport top (output mode, tick8, tick16, tick128, req_n, input accept);
  modport qual (input mode, tick8, tick16, tick128, req_n, output accept);
endinterface
`default_nettype wire

// *** logic/odq_qual.sv ***
// module: qualifies one synchronised active-low request input
`default_nettype none
module odq_qual
  import odq_pkg::*;
(
  input  wire logic i_ref_clk,
  input  wire logic i_reset,
  odq_chan_if.qual  chan
);
  typedef struct packed {
    logic       prev;
    logic [4:0] cnt;
    logic       acc;
  } odq_qst_t;
  odq_qst_t st;
  odq_qst_t next_st;
  logic     tick;

  always_comb begin
    case (chan.mode)
      ODQ_DIV8:   tick = chan.tick8;
      ODQ_DIV16:  tick = chan.tick16;
      ODQ_DIV128: tick = chan.tick128;
      default:    tick = 1'b0;
    endcase
  end

  always_comb begin
    next_st      = st;
    next_st.acc  = 1'b0;
    next_st.prev = chan.req_n;
    if (chan.mode == ODQ_EDGE) begin
      next_st.cnt = 5'h0;
      next_st.acc = st.prev & ~chan.req_n;
    end else if (tick) begin
      if (chan.req_n) begin
        next_st.cnt = 5'h0;
      end else if (st.cnt == 5'(ODQ_SAMPLES - 1)) begin
        next_st.cnt = 5'h0;
        next_st.acc = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 5'h1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      st <= '{prev: 1'b1, cnt: 5'h0, acc: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign chan.accept = st.acc;
endmodule
`default_nettype wire

// *** logic/odq_top.sv ***
// module: output disable request qualifier with registers and interrupt
`default_nettype none
module odq_top
  import odq_pkg::*;
(
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_reset,
  input  wire logic                  i_first_disable_request_in_n,
  input  wire logic                  i_second_disable_request_in_n,
  input  wire logic [ODQ_ADDR_W-1:0] i_addr,
  input  wire logic [31:0]           i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic      [31:0]           o_rdata,
  output logic                       o_first_accept,
  output logic                       o_second_accept,
  output logic                       o_irq
);
  typedef struct packed {
    logic [2:0]           sync1;
    logic [2:0]           sync2;
    logic                 stab1;
    logic                 stab2;
    logic [ODQ_PRE_W-1:0] pre;
    logic                 t8;
    logic                 t16;
    logic                 t128;
    logic [1:0]           mode1;
    logic [1:0]           mode2;
    logic [1:0]           stat;
    logic [1:0]           mask;
    logic [31:0]          rdata;
    logic                 acc1;
    logic                 acc2;
    logic                 irq;
  } odq_st_t;

  odq_st_t    st;
  odq_st_t    next_st;
  odq_chan_if ch1 ();
  odq_chan_if ch2 ();

  function automatic logic div_hit(input logic [ODQ_PRE_W-1:0] p,
                                   input int d);
    // int arithmetic, since a divisor of 128 does not fit the prescaler width
    return (int'(p) % d) == (d - 1);
  endfunction

  assign ch1.mode    = st.mode1;
  assign ch1.tick8   = st.t8;
  assign ch1.tick16  = st.t16;
  assign ch1.tick128 = st.t128;
  assign ch1.req_n   = st.stab1;
  assign ch2.mode    = st.mode2;
  assign ch2.tick8   = st.t8;
  assign ch2.tick16  = st.t16;
  assign ch2.tick128 = st.t128;
  assign ch2.req_n   = st.stab2;

  odq_qual u_q1 (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .chan      (ch1)
  );

  odq_qual u_q2 (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .chan      (ch2)
  );

  always_comb begin
    logic [1:0] ev;
    ev      = {ch2.accept, ch1.accept};
    next_st = st;
    // three-stage pin synchronisers, stable level once stages 2 and 3 agree
    next_st.sync1 = {st.sync1[1:0], i_first_disable_request_in_n};
    next_st.sync2 = {st.sync2[1:0], i_second_disable_request_in_n};
    if (st.sync1[1] == st.sync1[2]) begin
      next_st.stab1 = st.sync1[2];
    end
    if (st.sync2[1] == st.sync2[2]) begin
      next_st.stab2 = st.sync2[2];
    end
    // prescaler for the sample enables
    next_st.pre  = st.pre + ODQ_PRE_W'(1);
    next_st.t8   = div_hit(st.pre, ODQ_DIV_A);
    next_st.t16  = div_hit(st.pre, ODQ_DIV_B);
    next_st.t128 = div_hit(st.pre, ODQ_DIV_C);
    // register writes
    if (i_wr) begin
      case (i_addr)
        ODQ_MODE_ADDR: begin
          next_st.mode1 = i_wdata[ODQ_M1_LO+:2];
          next_st.mode2 = i_wdata[ODQ_M2_LO+:2];
        end
        ODQ_STAT_ADDR: next_st.stat = st.stat & ~i_wdata[1:0];
        ODQ_MASK_ADDR: next_st.mask = i_wdata[1:0];
        default: ;
      endcase
    end
    // set wins over a clear in the same cycle
    next_st.stat = next_st.stat | ev;
    next_st.acc1 = ch1.accept;
    next_st.acc2 = ch2.accept;
    next_st.irq  = |(next_st.stat & next_st.mask);
    // register reads, data valid the cycle after the strobe
    next_st.rdata = 32'h0;
    if (i_rd) begin
      case (i_addr)
        ODQ_MODE_ADDR: begin
          next_st.rdata[ODQ_M1_LO+:2] = st.mode1;
          next_st.rdata[ODQ_M2_LO+:2] = st.mode2;
        end
        ODQ_STAT_ADDR: next_st.rdata[1:0] = st.stat;
        ODQ_MASK_ADDR: next_st.rdata[1:0] = st.mask;
        ODQ_LVL_ADDR:  next_st.rdata[1:0] = {st.stab2, st.stab1};
        default:       next_st.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      st       <= '0;
      st.sync1 <= 3'h7;
      st.sync2 <= 3'h7;
      st.stab1 <= 1'b1;
      st.stab2 <= 1'b1;
      st.mode1 <= ODQ_MODE_RST;
      st.mode2 <= ODQ_MODE_RST;
      st.stat  <= ODQ_STAT_RST;
      st.mask  <= ODQ_MASK_RST;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata         = st.rdata;
  assign o_first_accept  = st.acc1;
  assign o_second_accept = st.acc2;
  assign o_irq           = st.irq;
endmodule
`default_nettype wire

// *** bench/odq_top_assertions.sv ***
// checker: port assertions of the request qualifier
`default_nettype none
module odq_chk
  import odq_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_reset,
  input wire logic        i_first_disable_request_in_n,
  input wire logic        i_second_disable_request_in_n,
  input wire logic [3:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        o_first_accept,
  input wire logic        o_second_accept,
  input wire logic        o_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] mode_sh;
  logic [1:0] mask_sh;
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      mode_sh <= 4'h0;
      mask_sh <= 2'h0;
    end else if (i_wr && i_addr == ODQ_MODE_ADDR)
      mode_sh <= i_wdata[5:2];
    else if (i_wr && i_addr == ODQ_MASK_ADDR)
      mask_sh <= i_wdata[1:0];
  end
  a_rdata_idle:
    assert property (!$past(i_rd) |-> o_rdata == 32'h0) else $error("rdata");
  a_mode_readback:
    assert property (i_rd && i_addr == ODQ_MODE_ADDR |=>
      o_rdata[5:0] == {mode_sh, 2'h0}) else $error("mode read");
  a_first_single:
    assert property (o_first_accept |=> !o_first_accept) else $error("acc1");
  a_second_single:
    assert property (o_second_accept |=> !o_second_accept) else $error("acc2");
  a_first_irq_raise:
    assert property (o_first_accept && mask_sh[0] && $past(mask_sh[0])
      |-> o_irq) else $error("irq1");
  a_second_irq_raise:
    assert property (o_second_accept && mask_sh[1] && $past(mask_sh[1])
      |-> o_irq) else $error("irq2");
  a_irq_masked_off:
    assert property (mask_sh == 2'h0 && $past(mask_sh) == 2'h0 |-> !o_irq)
      else $error("masked irq");
  a_irq_w1c_clear:
    assert property (i_wr && i_addr == ODQ_STAT_ADDR && i_wdata[1:0] == 2'h3
      |=> !o_irq || o_first_accept || o_second_accept) else $error("w1c");
endmodule
bind odq_top odq_chk i_odq_chk (.i_ref_clk, .i_reset,
  .i_first_disable_request_in_n, .i_second_disable_request_in_n, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .o_first_accept, .o_second_accept,
  .o_irq);
`default_nettype wire

// *** bench/odq_pin_model.sv ***
// partner: two board-side active-low request lines
`default_nettype none
module odq_pin_model (
  input  wire logic        i_ref_clk,
  input  wire logic [1:0]  i_go,
  input  wire logic [11:0] i_len,
  output logic      [1:0]  o_pin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] left [2] = '{12'h0, 12'h0};
  // low for i_len cycles after go, else pulled high
  always @(posedge i_ref_clk)
    for (int k = 0; k < 2; k++)
      left[k] <= i_go[k] ? i_len : left[k] - 12'(left[k] != 12'h0);
  assign o_pin_n = {left[1] == 12'h0, left[0] == 12'h0};
endmodule
`default_nettype wire

// *** bench/odq_top_tb_top.sv ***
// bench: testbench of the request qualifier
`default_nettype none
module odq_top_tb_top
  import odq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_ref_clk = 1'h0;
  logic        i_reset = 1'h1;
  logic        i_wr = 1'h0;
  logic        i_rd = 1'h0;
  logic        rd_d = 1'h0;
  logic [3:0]  i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic [1:0]  go = 2'h0;
  logic [11:0] len = 12'h0;
  logic [31:0] seed = 32'h1665a;
  logic [1:0]  pin_n;
  logic [31:0] o_rdata, dq [$];
  logic        o_first_accept, o_second_accept, o_irq, accq [$];
  int          miscompares = 0, comparisons = 0, cyc = 0;
  always #50 i_ref_clk = ~i_ref_clk;
  odq_top i_odq_top (.i_ref_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd,
    .i_first_disable_request_in_n(pin_n[0]), .o_rdata, .o_first_accept,
    .i_second_disable_request_in_n(pin_n[1]), .o_second_accept, .o_irq);
  odq_pin_model i_odq_pin_model (.i_ref_clk, .i_go(go), .i_len(len),
    .o_pin_n(pin_n));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t data %h not %h", $time, got, exp);
    end
  endtask
  task automatic cmp_acc(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t accept on wrong input", $time);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= w;
    i_rd <= !w;
    i_addr <= a;
    i_wdata <= d;
    if (!w) dq.push_back(d);
    @(posedge i_ref_clk);
    i_wr <= 1'h0;
    i_rd <= 1'h0;
  endtask
  task automatic pulse(input int p, input int n);
    @(posedge i_ref_clk);
    go <= 2'(1 << p);
    len <= 12'(n);
    @(posedge i_ref_clk);
    go <= 2'h0;
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic run(input int p, input int m);
    int d;
    logic [31:0] mv;
    d = (m == 3) ? 128 : (m == 2) ? 16 : 8;
    mv = 32'(m) << (p ? ODQ_M2_LO : ODQ_M1_LO);
    bus(1'h1, ODQ_MODE_ADDR, mv);
    bus(1'h0, ODQ_MODE_ADDR, mv);
    accq.push_back(p[0]);
    pulse(p, 20 * d + int'(rnd() % 32'(d)));
    repeat (d + 20) @(posedge i_ref_clk);
    bus(1'h0, ODQ_STAT_ADDR, 32'(p + 1));
    cmp_data(32'(o_irq), 32'h1);
    bus(1'h1, ODQ_STAT_ADDR, 32'h3);
    @(posedge i_ref_clk);
    cmp_data(32'(o_irq), 32'h0);
    if (m == 0) accq = {accq, p[0], p[0]};
    pulse(p, 12 * d);
    repeat (2 * d) @(posedge i_ref_clk);
    pulse(p, 12 * d);
    repeat (d + 20) @(posedge i_ref_clk);
    bus(1'h0, ODQ_STAT_ADDR, m == 0 ? 32'(p + 1) : 32'h0);
    bus(1'h1, ODQ_STAT_ADDR, 32'h3);
  endtask
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      conclude();
    end else begin
      if (rd_d) cmp_data(o_rdata, dq.pop_front());
      if (o_first_accept === 1'h1 || o_second_accept === 1'h1)
        cmp_acc(o_second_accept, accq.size() > 0 ? accq.pop_front() : 1'hx);
      rd_d <= i_rd;
    end
  end
  initial begin
    logic [31:0] v;
    repeat (16) @(posedge i_ref_clk);
    i_reset <= 1'h0;
    bus(1'h0, ODQ_MODE_ADDR, 32'h0);
    bus(1'h0, ODQ_STAT_ADDR, 32'h0);
    bus(1'h0, 4'h2, 32'h0);
    v = rnd();
    bus(1'h1, ODQ_MASK_ADDR, v);
    bus(1'h0, ODQ_MASK_ADDR, {30'h0, v[1:0]});
    bus(1'h1, ODQ_MASK_ADDR, 32'h3);
    for (int p = 0; p < 2; p++)
      for (int m = 0; m < 4; m++)
        if (p == 1 || m < 3)
          run(p, m);
    cmp_data(32'(accq.size()), 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
